// [mrac_chk.sv]
// Checker of the converter serial control block ports
`timescale 1ns/1ps
`include "mrac_map.vh"
module mrac_chk #(
   parameter NUM_CHAN = `MRAC_NUM_CHAN_LARGE
) (
   // Clock and reset
   input logic CLK,
   input logic RESETN,
   // Serial pins
   input logic CS_N,
   input logic DOUT_O,
   input logic DOUT_OE,
   input logic RESULT_STROBE,
   // Core side
   input logic INT_CLK_MODE,
   input logic CONV_DONE,
   input logic [`MRAC_RES_W-1:0] CONV_RESULT,
   // Configuration
   input logic [NUM_CHAN-1:0] CHAN_PAIRED,
   input logic [`MRAC_RNG_W*NUM_CHAN-1:0] CHAN_RANGE,
   input logic CFG_VALID,
   input logic CFG_REJECT,
   input logic [2:0] CFG_CHANNEL
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   // Result MSB, so past() sees a plain signal
   wire res_msb = CONV_RESULT[`MRAC_RES_W-1];
   wire [2:0] cfg_rng = CHAN_RANGE[CFG_CHANNEL*3 +: 3];

   strobe_ext_a: assert property (!INT_CLK_MODE |=> !RESULT_STROBE)
      else $error("strobe high in external mode");
   strobe_rise_a: assert property (CONV_DONE && INT_CLK_MODE |=> RESULT_STROBE)
      else $error("strobe missing after conversion");
   // Synced select lags the pin; three high samples mean no clear is pending
   strobe_hold_a: assert property (CS_N [*3] ##0 (RESULT_STROBE && INT_CLK_MODE)
      |=> RESULT_STROBE)
      else $error("strobe dropped while deselected");
   msb_first_a: assert property (CONV_DONE |=> DOUT_O == $past(res_msb))
      else $error("result msb not on serial out");
   oe_on_a: assert property (!CS_N [*5] |-> DOUT_OE)
      else $error("serial out not driven while selected");
   oe_off_a: assert property (CS_N [*5] |-> !DOUT_OE)
      else $error("serial out driven while deselected");
   quiet_high_a: assert property (CS_N [*6] |-> !CFG_VALID && !CFG_REJECT)
      else $error("byte event while deselected");
   pulse_one_a: assert property (CFG_VALID |-> !CFG_REJECT ##1 !CFG_VALID)
      else $error("stored pulse malformed");
   reject_keep_a: assert property (CFG_REJECT |-> $stable(CHAN_RANGE) && $stable(CHAN_PAIRED))
      else $error("refused byte changed settings");
   se_range_a: assert property (CFG_VALID |-> cfg_rng != 3'h0)
      else $error("stored range code zero");
   dif_range_a: assert property (CFG_VALID && CHAN_PAIRED[CFG_CHANNEL] |-> cfg_rng <= 3'h3)
      else $error("pair range out of set");
endmodule // mrac_chk

bind mrac_ctrl mrac_chk #(.NUM_CHAN(NUM_CHAN)) u_chk (
   .CLK(CLK), .RESETN(RESETN), .CS_N(CS_N), .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE),
   .RESULT_STROBE(RESULT_STROBE), .INT_CLK_MODE(INT_CLK_MODE), .CONV_DONE(CONV_DONE),
   .CONV_RESULT(CONV_RESULT), .CHAN_PAIRED(CHAN_PAIRED), .CHAN_RANGE(CHAN_RANGE),
   .CFG_VALID(CFG_VALID), .CFG_REJECT(CFG_REJECT), .CFG_CHANNEL(CFG_CHANNEL)
);

// [mrac_ctrl.v]
// Serial port and channel configuration store of the multirange converter
`timescale 1ns/1ps
`include "mrac_map.vh"
module mrac_ctrl #(
   parameter NUM_CHAN = `MRAC_NUM_CHAN_LARGE
) (
   // Clock and reset
   input wire CLK,
   input wire RESETN,
   // Serial pins from the host
   input wire CS_N,
   input wire SCLK,
   input wire DIN,
   // Serial data out, released when not selected
   output wire DOUT_O,
   output wire DOUT_OE,
   // Result ready strobe, always driven
   output wire RESULT_STROBE,
   // Mode and conversion core, same clock domain
   input wire INT_CLK_MODE,
   input wire CONV_DONE,
   input wire [`MRAC_RES_W-1:0] CONV_RESULT,
   // Per-channel configuration
   output wire [NUM_CHAN-1:0] CHAN_PAIRED,
   output wire [`MRAC_RNG_W*NUM_CHAN-1:0] CHAN_RANGE,
   // Configuration byte events
   output wire CFG_VALID,
   output wire CFG_REJECT,
   output wire [2:0] CFG_CHANNEL
);
   wire [2:0] pins_sync;
   wire cs_n_s;
   wire sclk_s;
   wire din_s;
   reg sclk_prev_q;
   reg cs_prev_q;
   wire sclk_rise;
   wire sclk_fall;
   wire cs_fall;
   wire selected;

   // Chip select resets high so the port starts deselected
   mrac_sync #(
      .WIDTH(3),
      .RESET_VAL(3'h4)
   ) u_sync (
      .CLK(CLK),
      .RESETN(RESETN),
      .ASYNC_IN({CS_N, SCLK, DIN}),
      .SYNC_OUT(pins_sync)
   );

   assign cs_n_s = pins_sync[2];
   assign sclk_s = pins_sync[1];
   assign din_s = pins_sync[0];

   // Edge history taken from synchronised copies only
   always @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end
      else
      begin
         sclk_prev_q <= sclk_s;
         cs_prev_q <= cs_n_s;
      end
   end

   // Clock edges count only while selected
   assign selected = ~cs_n_s;
   assign sclk_rise = selected & sclk_s & ~sclk_prev_q;
   assign sclk_fall = selected & ~sclk_s & sclk_prev_q;
   assign cs_fall = cs_prev_q & ~cs_n_s;

   // Configuration byte receiver
   localparam [1:0] ST_HUNT = 2'b01;
   localparam [1:0] ST_BITS = 2'b10;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [`MRAC_CNT_W-1:0] cnt_q;
   reg [`MRAC_CNT_W-1:0] cnt_d;
   reg [`MRAC_BYTE_W-2:0] body_q;
   reg [`MRAC_BYTE_W-2:0] body_d;
   reg byte_done;
   wire [`MRAC_BYTE_W-1:0] cfg_byte;

   // Start bit search, then seven more bits MSB first
   always @*
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      body_d = body_q;
      byte_done = 1'b0;
      if (cs_n_s)
      begin
         // Partial byte dropped on deselect
         state_d = ST_HUNT;
         cnt_d = {`MRAC_CNT_W{1'b0}};
      end
      else if (sclk_rise)
      begin
         case (state_q)
            ST_HUNT:
            begin
               // Leading zeros are padding; first one is bit 7
               if (din_s)
               begin
                  state_d = ST_BITS;
                  cnt_d = `MRAC_BITS_AFTER_START;
               end
            end
            ST_BITS:
            begin
               body_d = {body_q[`MRAC_BYTE_W-3:0], din_s};
               cnt_d = cnt_q - 3'h1;
               if (cnt_q == 3'h1)
               begin
                  byte_done = 1'b1;
                  state_d = ST_HUNT;
               end
            end
            default:
            begin
               state_d = ST_HUNT;
            end
         endcase
      end
   end

   always @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state_q <= ST_HUNT;
         cnt_q <= {`MRAC_CNT_W{1'b0}};
         body_q <= {(`MRAC_BYTE_W-1){1'b0}};
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         body_q <= body_d;
      end
   end

   // Last body bit is still in body_d when the byte completes
   assign cfg_byte = {1'b1, body_d};

   // Byte decode and range check
   wire [2:0] sel_chan;
   wire sel_pair;
   wire [`MRAC_RNG_W-1:0] sel_rng;
   wire chan_ok;
   wire rng_ok;
   wire cfg_write;

   assign sel_chan = cfg_byte[`MRAC_CH_MSB:`MRAC_CH_LSB];
   assign sel_pair = cfg_byte[`MRAC_PAIR_POS];
   assign sel_rng = cfg_byte[`MRAC_RNG_MSB:`MRAC_RNG_LSB];

   // Channels numbered at or above the build's count do not exist
   assign chan_ok = ({1'b0, sel_chan} < NUM_CHAN[3:0]);

   // Seven single-ended codes, three differential codes
   assign rng_ok = sel_pair ?
      (sel_rng >= `MRAC_DIF_RNG_MIN && sel_rng <= `MRAC_DIF_RNG_MAX) :
      (sel_rng >= `MRAC_SE_RNG_MIN && sel_rng <= `MRAC_SE_RNG_MAX);

   // An illegal byte leaves the old setting intact rather than half-apply it
   assign cfg_write = byte_done & chan_ok & rng_ok;

   reg cfg_valid_q;
   reg cfg_reject_q;
   reg [2:0] cfg_chan_q;

   // Report each completed byte to the core
   always @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         cfg_valid_q <= 1'b0;
         cfg_reject_q <= 1'b0;
         cfg_chan_q <= 3'h0;
      end
      else
      begin
         cfg_valid_q <= cfg_write;
         cfg_reject_q <= byte_done & ~cfg_write;
         if (byte_done)
         begin
            cfg_chan_q <= sel_chan;
         end
      end
   end

   assign CFG_VALID = cfg_valid_q;
   assign CFG_REJECT = cfg_reject_q;
   assign CFG_CHANNEL = cfg_chan_q;

   // Per-channel pairing and range store
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch = ch + 1)
      begin : g_chan
         reg pair_q;
         reg [`MRAC_RNG_W-1:0] rng_q;
         // Each channel updates only when addressed
         always @(posedge CLK or negedge RESETN)
         begin
            if (!RESETN)
            begin
               pair_q <= `MRAC_PAIR_RST;
               rng_q <= `MRAC_RNG_RST;
            end
            else if (cfg_write && sel_chan == ch)
            begin
               pair_q <= sel_pair;
               rng_q <= sel_rng;
            end
         end
         assign CHAN_PAIRED[ch] = pair_q;
         assign CHAN_RANGE[`MRAC_RNG_W*ch +: `MRAC_RNG_W] = rng_q;
      end
   endgenerate

   // Result shifter and data out
   reg [`MRAC_RES_W-1:0] res_q;
   reg dout_q;
   reg oe_q;

   // New result loads whole; falling edges walk it out MSB first
   always @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         res_q <= {`MRAC_RES_W{1'b0}};
         dout_q <= 1'b0;
      end
      else if (CONV_DONE)
      begin
         res_q <= {CONV_RESULT[`MRAC_RES_W-2:0], 1'b0};
         dout_q <= CONV_RESULT[`MRAC_RES_W-1];
      end
      else if (sclk_fall)
      begin
         dout_q <= res_q[`MRAC_RES_W-1];
         res_q <= {res_q[`MRAC_RES_W-2:0], 1'b0};
      end
   end

   // Enable from a flop so the pin never glitches on
   always @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         oe_q <= 1'b0;
      end
      else
      begin
         oe_q <= selected;
      end
   end

   assign DOUT_O = dout_q;
   assign DOUT_OE = oe_q;

   // Result strobe
   reg strobe_q;

   // Set on a finished conversion, cleared as the host starts reading;
   // a result landing in the clearing cycle keeps the strobe up
   always @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         strobe_q <= 1'b0;
      end
      else if (!INT_CLK_MODE)
      begin
         strobe_q <= 1'b0;
      end
      else if (CONV_DONE)
      begin
         strobe_q <= 1'b1;
      end
      else if (sclk_fall || cs_fall)
      begin
         strobe_q <= 1'b0;
      end
   end

   // Plain output, no enable: always driven
   assign RESULT_STROBE = strobe_q;

endmodule // mrac_ctrl

// [mrac_host.sv]
// Host model: serial master that frames bytes and reads results
`timescale 1ns/1ps
module mrac_host (
   // Clock
   input logic clk,
   // Serial pins
   output logic cs_n,
   output logic sclk,
   output logic din,
   input logic dout
);
   // Idle: deselected, clock low
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   // Select edge, then a settle gap before the first bit
   task frame(input logic sel);
      @(posedge clk);
      cs_n <= !sel;
      repeat (8) @(posedge clk);
   endtask
   // Data set in the low phase, read late so the slow sync has landed
   task bit_x(input logic d, output logic q);
      din <= d;
      repeat (8) @(posedge clk);
      q = dout;
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
   endtask
   // Short counts only used to cut a byte on purpose
   task send(input logic [7:0] b, input int n);
      logic q;
      for (int i = 7; i > 7 - n; i--)
         bit_x(b[i], q);
   endtask
   // Result word, msb first
   task read14(output logic [13:0] r);
      for (int i = 13; i >= 0; i--)
         bit_x(1'b0, r[i]);
   endtask
endmodule // mrac_host

// [mrac_map.vh]
// Constants for the multirange converter serial control block
// Summary of operation
// - With chip select low, the serial input is captured on each rising serial clock edge.
// - With chip select low, the next output bit is shifted out on each falling serial clock edge.
// - With chip select high, clock and data are ignored and the serial output is released.
// - In internal clock mode a rising result strobe tells the host that a result is ready.
// - In external clock mode the result strobe is held low.
// - The result strobe is always driven, whatever chip select does.
// - Each conversion yields a fourteen-bit result word.
// - The large build has eight single-ended inputs or four differential pairs.
// - The small build has four single-ended inputs or two pairs; channel count is a parameter.
// - Each channel keeps its own range; single-ended use offers seven ranges.
// - Differential use offers three ranges.
// - The first one clocked in after chip select falls is bit 7 of the configuration byte.
// - Bits 6 to 4 of the byte select the channel being configured.
// - Bit 3 selects single-ended (0) or differential (1) operation for that channel.
// - The low three bits are the range code, stored per channel.
`ifndef MRAC_MAP_VH
`define MRAC_MAP_VH
`define MRAC_RES_W 14
`define MRAC_BYTE_W 8
`define MRAC_START_POS 7
`define MRAC_CH_MSB 6
`define MRAC_CH_LSB 4
`define MRAC_PAIR_POS 3
`define MRAC_RNG_MSB 2
`define MRAC_RNG_LSB 0
`define MRAC_RNG_W 3
`define MRAC_CNT_W 3
`define MRAC_BITS_AFTER_START 3'h7
`define MRAC_PAIR_RST 1'b0
`define MRAC_RNG_RST 3'h7
`define MRAC_SE_RNG_MIN 3'h1
`define MRAC_SE_RNG_MAX 3'h7
`define MRAC_DIF_RNG_MIN 3'h1
`define MRAC_DIF_RNG_MAX 3'h3
`define MRAC_NUM_CHAN_LARGE 8
`define MRAC_NUM_CHAN_SMALL 4
`endif

// [mrac_sync.v]
// Two-stage synchroniser for pins entering the CLK domain
`timescale 1ns/1ps
module mrac_sync #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   // Clock and reset
   input wire CLK,
   input wire RESETN,
   // Asynchronous in, synchronous out
   input wire [WIDTH-1:0] ASYNC_IN,
   output wire [WIDTH-1:0] SYNC_OUT
);
   genvar i;
   // One pair of flops per bit; first stage feeds only the second
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         reg meta_q;
         reg sync_q;
         always @(posedge CLK or negedge RESETN)
         begin
            if (!RESETN)
            begin
               meta_q <= RESET_VAL[i];
               sync_q <= RESET_VAL[i];
            end
            else
            begin
               meta_q <= ASYNC_IN[i];
               sync_q <= meta_q;
            end
         end
         assign SYNC_OUT[i] = sync_q;
      end
   endgenerate
endmodule // mrac_sync

// [testbench.sv]
// Self-checking bench of the converter serial control block
`timescale 1ns/1ps
`include "mrac_map.vh"
module testbench;
   localparam NCH = `MRAC_NUM_CHAN_LARGE;
   logic clk;
   logic resetn;
   logic int_clk_mode;
   logic conv_done;
   logic [13:0] conv_result;
   wire [`MRAC_NUM_CHAN_SMALL-1:0] s_paired;
   wire [3*`MRAC_NUM_CHAN_SMALL-1:0] s_range;
   wire s_reject;
   int n_sbad = 0;
   wire cs_n, sclk, din, dout_o, dout_oe, result_strobe, cfg_valid, cfg_reject;
   wire [NCH-1:0] chan_paired;
   wire [3*NCH-1:0] chan_range;
   wire [2:0] cfg_channel;
   int n_fail = 0;
   int total_checks = 0;
   int n_ok = 0;
   int n_bad = 0;
   // Released line shows the inverse, never a stale value
   wire dout_w = dout_oe ? dout_o : ~dout_o;

   always #2 clk = ~clk;

   mrac_ctrl #(.NUM_CHAN(NCH)) i_dut (
      .CLK(clk), .RESETN(resetn), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
      .DOUT_O(dout_o), .DOUT_OE(dout_oe), .RESULT_STROBE(result_strobe),
      .INT_CLK_MODE(int_clk_mode), .CONV_DONE(conv_done), .CONV_RESULT(conv_result),
      .CHAN_PAIRED(chan_paired), .CHAN_RANGE(chan_range), .CFG_VALID(cfg_valid),
      .CFG_REJECT(cfg_reject), .CFG_CHANNEL(cfg_channel)
   );
   mrac_host i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_w));

   // Small build on the same pins; only its store and refusals are judged
   mrac_ctrl #(.NUM_CHAN(`MRAC_NUM_CHAN_SMALL)) i_dut_small (
      .CLK(clk), .RESETN(resetn), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
      .DOUT_O(), .DOUT_OE(), .RESULT_STROBE(),
      .INT_CLK_MODE(int_clk_mode), .CONV_DONE(conv_done), .CONV_RESULT(conv_result),
      .CHAN_PAIRED(s_paired), .CHAN_RANGE(s_range), .CFG_VALID(),
      .CFG_REJECT(s_reject), .CFG_CHANNEL()
   );

   // Count stored and refused byte pulses
   always @(posedge clk)
   begin
      n_ok <= n_ok + cfg_valid;
      n_bad <= n_bad + cfg_reject;
      n_sbad <= n_sbad + s_reject;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
      end
   endtask

   task report_and_stop;
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task t_reset;
      @(posedge clk);
      #1;
      check(chan_range, {NCH{3'h7}});
      check(s_range, {`MRAC_NUM_CHAN_SMALL{3'h7}});
      check(chan_paired, 0);
      check(dout_oe, 0);
      check(result_strobe, 0);
      $display("done: reset");
   endtask

   // Every range code once, pairing from its low bit, all in one frame
   task t_config;
      logic [2:0] r;
      logic legal;
      logic [3*NCH-1:0] er;
      logic [NCH-1:0] ep;
      int eo;
      int eb;
      int esb;
      er = {NCH{3'h7}};
      ep = 0;
      eo = n_ok;
      eb = n_bad;
      esb = n_sbad;
      i_host.frame(1'b1);
      i_host.send(8'h00, 8);
      for (int k = 0; k < 8; k++)
      begin
         r = k[2:0];
         i_host.send({1'b1, r, r[0], r}, 8);
         legal = (r != 3'h0) && (!r[0] || r <= 3'h3);
         if (legal)
         begin
            er[3*k +: 3] = r;
            ep[k] = r[0];
         end
         eo = eo + legal;
         eb = eb + !legal;
         // Small build has no channels 4 to 7
         esb = esb + (!legal || k >= `MRAC_NUM_CHAN_SMALL);
         check(n_ok, eo);
         check(n_bad, eb);
      end
      i_host.frame(1'b0);
      check(chan_range, er);
      check(chan_paired, ep);
      check(cfg_channel, 3'h7);
      check(s_range, er[3*`MRAC_NUM_CHAN_SMALL-1:0]);
      check(s_paired, ep[`MRAC_NUM_CHAN_SMALL-1:0]);
      check(n_sbad, esb);
      $display("done: config");
   endtask

   // Cut byte, clocking while deselected, then a clean byte
   task t_abort;
      int s;
      s = n_ok + n_bad;
      i_host.frame(1'b1);
      i_host.send(8'hd0, 4);
      i_host.frame(1'b0);
      i_host.send(8'hb2, 8);
      check(dout_oe, 0);
      check(n_ok + n_bad, s);
      i_host.frame(1'b1);
      i_host.send(8'h95, 8);
      i_host.frame(1'b0);
      check(chan_range[5:3], 3'h5);
      check(chan_paired[1], 0);
      check(chan_range[11:9], 3'h3);
      $display("done: abort");
   endtask

   task t_conv(input logic mode, input logic [13:0] v);
      logic [13:0] rd;
      int_clk_mode <= mode;
      conv_result <= v;
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      @(posedge clk);
      #1;
      check(result_strobe, mode);
      repeat (6) @(posedge clk);
      check(result_strobe, mode);
      i_host.frame(1'b1);
      i_host.read14(rd);
      check(rd, v);
      check(result_strobe, 0);
      i_host.frame(1'b0);
      $display("done: conversion");
   endtask

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      int_clk_mode = 1'b0;
      conv_done = 1'b0;
      conv_result = 14'h0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_config;
      t_abort;
      t_conv(1'b1, 14'h2a5c);
      t_conv(1'b0, 14'h1357);
      report_and_stop;
   end

   // Hang guard, well beyond the few thousand cycles needed
   initial
   begin
      repeat (30000) @(posedge clk);
      n_fail++;
      report_and_stop;
   end
endmodule // testbench
